// >>> dacs_defs.svh
// Constants for the dual-channel converter serial sequencer
`ifndef DACS_DEFS_SVH
`define DACS_DEFS_SVH

`define DACS_RES_BITS      10
`define DACS_CTRL_BITS     8
`define DACS_ADDR_LOW_POS  3
`define DACS_ADDR_MID_POS  4
`define DACS_ADDR_TOP_POS  5

`define DACS_SLOT_IDLE     5'h00
`define DACS_SLOT_FIRST    5'h01
`define DACS_TRACK_LAST    5'h03
`define DACS_HOLD_SLOT     5'h04
`define DACS_MSB_SLOT      5'h05
`define DACS_LSB_SLOT      5'h0E
`define DACS_CTRL_LAST     5'h08
`define DACS_CONV_SLOTS    5'h10

`define DACS_CHAN_RST      1'h0
`define DACS_CTRL_RST      8'h00

`endif

// >>> dacs_edge_gate.sv
// Gated internal serial clock edges, blocked while chip select is high
`timescale 1ns/1ps
module dacs_edge_gate (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    clk_en,
    input  wire dacs_pkg::dacs_pins_type pins,
    output dacs_pkg::dacs_edges_type     edges
);
    import dacs_pkg::*;

    logic cs_prev_r;
    logic sclk_prev_r;
    wire  cs_fall_low;
    wire  sclk_fall;
    wire  sclk_rise;

    // Chip select falling with clock parked low counts as a falling edge
    assign cs_fall_low = cs_prev_r & ~pins.cs_n & ~pins.sclk;
    assign sclk_fall   = ~cs_prev_r & ~pins.cs_n
                         & sclk_prev_r & ~pins.sclk;
    assign sclk_rise   = ~cs_prev_r & ~pins.cs_n
                         & ~sclk_prev_r & pins.sclk;

    assign edges.fall = cs_fall_low | sclk_fall;
    assign edges.rise = sclk_rise;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_prev_r   <= 1'b1;
            sclk_prev_r <= 1'b0;
        end else if (clk_en) begin
            cs_prev_r   <= pins.cs_n;
            sclk_prev_r <= pins.sclk;
        end
    end
endmodule

// >>> dacs_host_model.sv
// Host-side serial master that frames conversions and reads results
`timescale 1ns/1ps
module dacs_host_model (
    input  wire logic clk,
    input  wire logic dout_pin,
    output logic      cs_n,
    output logic      sclk,
    output logic      din
);
    logic [7:0]  ctrl [4];
    logic [15:0] res  [4];
    logic [15:0] shf;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din  = 1'b0;
        shf  = 16'h0000;
    end

    // Four system clocks per serial clock level
    task automatic half();
        repeat (4) @(negedge clk);
    endtask

    // Toggle the serial clock while deselected
    task automatic idle(input int n);
        for (int i = 0; i < n; i++) begin
            sclk = ~sclk;
            half();
        end
    endtask

    task automatic frame(input int nrise, input logic park_high);
        int k;
        int c;
        sclk = park_high;
        half();
        cs_n = 1'b0;
        for (int r = 0; r < nrise; r++) begin
            k = r % 16;
            c = r / 16;
            if (r != 0 || park_high) begin
                if (r == 0)
                    half();
                sclk = 1'b0;
            end
            // Bits past the eighth are ignored, so they toggle
            din = (k < 8) ? ctrl[c][7-k] : ~din;
            half();
            shf = {shf[14:0], dout_pin};
            sclk = 1'b1;
            if (k == 15)
                res[c] = shf;
            half();
        end
        cs_n = 1'b1;
        half();
    endtask
endmodule

// >>> dacs_pkg.sv
// Types shared by the converter serial sequencer
package dacs_pkg;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
    } dacs_pins_type;

    typedef struct packed {
        logic fall;
        logic rise;
    } dacs_edges_type;

    typedef enum logic [2:0] {
        DACS_IDLE    = 3'b001,
        DACS_TRACK   = 3'b010,
        DACS_CONVERT = 3'b100
    } dacs_phase_type;

endpackage

// >>> dacs_sar_core.sv
// Successive-approximation engine, one result bit per step, MSB first
`timescale 1ns/1ps
`include "dacs_defs.svh"
module dacs_sar_core #(
    parameter int RES_BITS = `DACS_RES_BITS
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                clk_en,
    input  wire logic                start,
    input  wire logic                step,
    input  wire logic [RES_BITS-1:0] level,
    output logic                     cmp_bit
);
    import dacs_pkg::*;

    logic [RES_BITS-1:0] sample_r;
    logic [RES_BITS-1:0] acc_r;
    logic [RES_BITS-1:0] trial_r;
    wire  [RES_BITS-1:0] guess;

    // Straight binary: compare held sample to next trial code
    assign guess = acc_r | trial_r;
    assign cmp_bit = (sample_r >= guess);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_r <= '0;
            acc_r    <= '0;
            trial_r  <= '0;
        end else if (clk_en) begin
            if (start) begin
                sample_r <= level;
                acc_r    <= '0;
                trial_r  <= {1'b1, {(RES_BITS-1){1'b0}}};
            end else if (step) begin
                acc_r   <= cmp_bit ? guess : acc_r;
                trial_r <= trial_r >> 1;
            end
        end
    end
endmodule

// >>> dacs_sequencer.sv
// Serial frame sequencer of a two-channel 10-bit converter
`timescale 1ns/1ps
`include "dacs_defs.svh"

// What this block does
// - First 3 serial clock cycles of each conversion are track mode.
// - Next 13 cycles hold the sample and run the approximation.
// - Result leaves MSB first, starting at the fifth clock.
// - Result output driven only while chip select is low.
// - Powered down while chip select high and between conversions.
// - Track after each 16th rising edge, hold on the following 4th fall.
// - Serial clock edges are blocked while chip select is high.
// - Chip select falling with clock low acts as first falling edge.
// - Clock parked high: track starts on first falling edge after select.
// - Control word captured on first 8 rising edges of each conversion.
// - Captured channel applies to the next conversion, not this one.
// - Control bits 5 to 3 address the channel, others ignored.
// - Low address bit picks first or second input, mid and top bits ignored.
// - No warm-up needed; first conversion converts the first input.
// - Result is straight unsigned binary, step of supply over 1024.
// - Conversions repeat every 16 clocks while chip select is low.
// - Output changes after falling edges, host samples on rising.
module dacs_sequencer #(
    parameter int RES_BITS  = `DACS_RES_BITS,
    parameter int CTRL_BITS = `DACS_CTRL_BITS
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                clk_en,
    input  wire logic                chip_select_n,
    input  wire logic                serial_clock,
    input  wire logic                serial_control_in,
    input  wire logic [RES_BITS-1:0] first_analog_input,
    input  wire logic [RES_BITS-1:0] second_analog_input,
    output logic                     serial_result_out,
    output logic                     serial_result_oe,
    output logic                     track_mode,
    output logic                     power_down,
    output logic                     active_channel
);
    import dacs_pkg::*;

    logic                 rst_meta_r;
    logic                 rst_sync_n_r;
    logic [4:0]           slot_r;
    dacs_phase_type       phase_r;
    logic [CTRL_BITS-1:0] channel_select_word_r;
    logic                 chan_sel_r;
    logic                 chan_cur_r;
    logic                 dout_r;
    logic                 oe_r;
    logic                 track_r;
    logic                 pdown_r;

    dacs_pins_type        pins;
    dacs_edges_type       edges;
    wire                  sar_bit;
    wire                  slot_wrap;
    wire [4:0]            slot_nxt;
    dacs_phase_type       phase_nxt;
    wire                  hold_start;
    wire                  result_step;
    wire                  capture;
    wire                  capture_last;
    wire [CTRL_BITS-1:0]  word_nxt;
    wire                  chan_sel_nxt;
    wire                  chan_cur_nxt;
    wire                  dout_nxt;
    wire                  pdown_nxt;
    wire [RES_BITS-1:0]   sample_mux;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r   <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_r   <= 1'b1;
            rst_sync_n_r <= rst_meta_r;
        end
    end

    assign pins.cs_n = chip_select_n;
    assign pins.sclk = serial_clock;
    assign pins.din  = serial_control_in;

    dacs_edge_gate u_gate (
        .clk    (clk),
        .rst_n  (rst_sync_n_r),
        .clk_en (clk_en),
        .pins   (pins),
        .edges  (edges)
    );

    // Slot counter: 1..16 within a conversion, 0 outside a frame
    assign slot_wrap = (slot_r == `DACS_SLOT_IDLE)
                       || (slot_r == `DACS_CONV_SLOTS);
    assign slot_nxt  = chip_select_n ? `DACS_SLOT_IDLE
                     : !edges.fall   ? slot_r
                     : slot_wrap     ? `DACS_SLOT_FIRST
                     : slot_r + 5'h01;

    always_comb begin
        case (1'b1)
            (slot_nxt == `DACS_SLOT_IDLE):  phase_nxt = DACS_IDLE;
            (slot_nxt <= `DACS_TRACK_LAST): phase_nxt = DACS_TRACK;
            default:                        phase_nxt = DACS_CONVERT;
        endcase
    end

    assign hold_start  = edges.fall && (slot_nxt == `DACS_HOLD_SLOT);
    assign result_step = edges.fall && (slot_nxt >= `DACS_MSB_SLOT)
                         && (slot_nxt <= `DACS_LSB_SLOT);

    // Control word shifts in on rising edges 1..8 of each conversion
    assign capture      = edges.rise && (slot_r >= `DACS_SLOT_FIRST)
                          && (slot_r <= `DACS_CTRL_LAST);
    assign capture_last = capture && (slot_r == `DACS_CTRL_LAST);
    assign word_nxt     = capture
                          ? {channel_select_word_r[CTRL_BITS-2:0],
                             pins.din}
                          : channel_select_word_r;
    // Only the low address bit steers the mux; bits 7..4 and 2..0 dropped
    assign chan_sel_nxt = capture_last ? word_nxt[`DACS_ADDR_LOW_POS]
                                       : chan_sel_r;
    // Channel sampled at hold is the one captured in the prior conversion
    assign chan_cur_nxt = hold_start ? chan_sel_r : chan_cur_r;
    assign sample_mux   = chan_sel_r ? second_analog_input
                                     : first_analog_input;

    dacs_sar_core #(
        .RES_BITS (RES_BITS)
    ) u_sar (
        .clk      (clk),
        .rst_n    (rst_sync_n_r),
        .clk_en   (clk_en),
        .start    (hold_start),
        .step     (result_step),
        .level    (sample_mux),
        .cmp_bit  (sar_bit)
    );

    // New bit after each falling edge, zero in non-result slots
    assign dout_nxt  = chip_select_n ? 1'b0
                     : !edges.fall   ? dout_r
                     : result_step   ? sar_bit
                     : 1'b0;
    assign pdown_nxt = chip_select_n
                       || (slot_nxt == `DACS_CONV_SLOTS);

    always_ff @(posedge clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            slot_r  <= `DACS_SLOT_IDLE;
            phase_r <= DACS_IDLE;
            dout_r  <= 1'b0;
            oe_r    <= 1'b0;
            track_r <= 1'b0;
            pdown_r <= 1'b1;
        end else if (clk_en) begin
            slot_r  <= slot_nxt;
            phase_r <= phase_nxt;
            dout_r  <= dout_nxt;
            oe_r    <= ~chip_select_n;
            track_r <= (phase_nxt == DACS_TRACK);
            pdown_r <= pdown_nxt;
        end
    end

    // Channel state survives frames; reset picks the first input
    always_ff @(posedge clk or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            channel_select_word_r <= `DACS_CTRL_RST;
            chan_sel_r            <= `DACS_CHAN_RST;
            chan_cur_r            <= `DACS_CHAN_RST;
        end else if (clk_en) begin
            channel_select_word_r <= word_nxt;
            chan_sel_r            <= chan_sel_nxt;
            chan_cur_r            <= chan_cur_nxt;
        end
    end

    assign serial_result_out = dout_r;
    assign serial_result_oe  = oe_r;
    assign track_mode        = track_r;
    assign power_down        = pdown_r;
    assign active_channel    = chan_cur_r;

    oe_follows_cs_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        clk_en |=> (serial_result_oe == !$past(chip_select_n)))
        else $error("output enable does not follow chip select");

    track_three_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        (clk_en && edges.fall && slot_nxt == `DACS_SLOT_FIRST)
        |=> (track_mode && phase_r == DACS_TRACK))
        else $error("track mode not entered on first falling edge");

    hold_fourth_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        (clk_en && hold_start)
        |=> (!track_mode && phase_r == DACS_CONVERT
             && slot_r == `DACS_HOLD_SLOT))
        else $error("hold not entered on fourth falling edge");

    track_after_wrap_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        (clk_en && !chip_select_n && edges.fall
         && slot_r == `DACS_CONV_SLOTS)
        |=> (slot_r == `DACS_SLOT_FIRST && track_mode))
        else $error("conversion did not restart after sixteen slots");

    slot_bound_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        slot_r <= `DACS_CONV_SLOTS)
        else $error("slot counter out of range");

    pad_zero_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        (clk_en && edges.fall && !result_step) |=> !serial_result_out)
        else $error("non-result slot drove a one");

    out_stable_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        (clk_en && !chip_select_n && !edges.fall)
        |=> $stable(serial_result_out))
        else $error("result changed without a falling edge");

    pdown_cs_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        (clk_en && chip_select_n) |=> (power_down && slot_r == 5'h00))
        else $error("not powered down while deselected");

    gate_block_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        chip_select_n |-> (!edges.fall && !edges.rise))
        else $error("clock edge leaked while deselected");

    chan_keep_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        (!capture_last || !clk_en) |=> $stable(chan_sel_r))
        else $error("channel changed outside eighth capture");

    chan_next_conv_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        (clk_en && hold_start) |=> (active_channel == $past(chan_sel_r)))
        else $error("conversion used wrong channel");

    pdown_gap_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        (clk_en && !chip_select_n && edges.fall
         && slot_r == `DACS_CONV_SLOTS - 5'h01)
        |=> power_down)
        else $error("no power-down after sixteenth falling edge");

    pdown_wake_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        (clk_en && !chip_select_n && edges.fall && slot_wrap)
        |=> (!power_down && serial_result_oe))
        else $error("still powered down after first falling edge");

    track_slots_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        track_mode == (slot_r >= `DACS_SLOT_FIRST
                       && slot_r <= `DACS_TRACK_LAST))
        else $error("track mode outside slots one to three");

    park_low_start_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        (clk_en && $past(clk_en) && $fell(chip_select_n) && !serial_clock)
        |=> (slot_r == `DACS_SLOT_FIRST && track_mode))
        else $error("select fall with clock low did not start tracking");

    park_high_wait_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        (clk_en && $past(clk_en) && $fell(chip_select_n) && serial_clock)
        |=> (slot_r == `DACS_SLOT_IDLE && !track_mode))
        else $error("tracking started before first clock fall");

    ctrl_window_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        (clk_en && edges.rise && slot_r > `DACS_CTRL_LAST)
        |=> $stable(channel_select_word_r))
        else $error("control bit taken after eighth rising edge");

    idle_keep_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        (clk_en && chip_select_n)
        |=> ($stable(channel_select_word_r) && $stable(chan_sel_r)
             && $stable(active_channel)))
        else $error("control state moved while deselected");

    dout_idle_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        (clk_en && chip_select_n)
        |=> (!serial_result_out && !serial_result_oe))
        else $error("result driven while deselected");

    // Low clock enable must leave the slot counter and all five outputs untouched
    freeze_hold_a: assert property (
        @(posedge clk) disable iff (!rst_sync_n_r)
        !clk_en
        |=> ($stable(slot_r) && $stable(serial_result_out)
             && $stable(track_mode) && $stable(power_down)
             && $stable(serial_result_oe) && $stable(active_channel)))
        else $error("state moved while clock enable low");
endmodule

// >>> dacs_sequencer_tb.sv
// Self-checking bench for the converter serial sequencer
`timescale 1ns/1ps
module dacs_sequencer_tb;
    typedef struct {
        logic [7:0] ctrl;
        logic [9:0] in_a;
        logic [9:0] in_b;
        logic       park_high;
        logic [9:0] exp_res;
    } dacs_row_type;

    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         clk_en = 1'b1;
    logic [4:0]   frz;
    logic         cs_n;
    logic         sclk;
    logic         din;
    logic [9:0]   in_a = 10'h000;
    logic [9:0]   in_b = 10'h000;
    logic         serial_result_out;
    logic         serial_result_oe;
    logic         track_mode;
    logic         power_down;
    logic         active_channel;
    wire          dout_pin = serial_result_oe ? serial_result_out : 1'bz;
    wire [4:0]    stat_w = {track_mode, power_down, serial_result_oe,
                            serial_result_out, active_channel};
    logic [15:0]  trk_w;
    logic [15:0]  pd_w;
    logic [15:0]  trk_s [4];
    logic [15:0]  pd_s  [4];
    logic         ch_s  [4];
    logic         chan;
    int           nr;
    int           checks = 0;
    int           n_mismatch = 0;
    dacs_row_type rows [6] = '{
        '{8'h08, 10'h3FF, 10'h000, 1'b0, 10'h3FF},
        '{8'h28, 10'h000, 10'h155, 1'b1, 10'h155},
        '{8'hC7, 10'h2AA, 10'h200, 1'b0, 10'h200},
        '{8'h00, 10'h001, 10'h3FF, 1'b1, 10'h001},
        '{8'hE8, 10'h200, 10'h000, 1'b0, 10'h200},
        '{8'h20, 10'h111, 10'h3FE, 1'b1, 10'h3FE}};

    always #10 clk = ~clk;

    dacs_sequencer i_dacs_sequencer (
        .clk                 (clk),
        .rst_n               (rst_n),
        .clk_en              (clk_en),
        .chip_select_n       (cs_n),
        .serial_clock        (sclk),
        .serial_control_in   (din),
        .first_analog_input  (in_a),
        .second_analog_input (in_b),
        .serial_result_out   (serial_result_out),
        .serial_result_oe    (serial_result_oe),
        .track_mode          (track_mode),
        .power_down          (power_down),
        .active_channel      (active_channel)
    );

    dacs_host_model i_dacs_host_model (
        .clk      (clk),
        .dout_pin (dout_pin),
        .cs_n     (cs_n),
        .sclk     (sclk),
        .din      (din)
    );

    // Per-conversion record of status outputs at each rising serial edge
    always @(negedge cs_n) nr = 0;
    always @(posedge sclk) begin
        if (cs_n === 1'b0) begin
            trk_w = {trk_w[14:0], track_mode};
            pd_w = {pd_w[14:0], power_down};
            nr++;
            if (nr % 16 == 0) begin
                trk_s[nr/16-1] = trk_w;
                pd_s[nr/16-1] = pd_w;
                ch_s[nr/16-1] = active_channel;
            end
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic do_reset();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        check(16'({power_down, serial_result_oe, track_mode, active_channel,
                   serial_result_out}), 16'h0010, "reset outputs");
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask

    task automatic conv_check(input int c, input logic [9:0] v,
                              input logic ch);
        check(i_dacs_host_model.res[c], {4'h0, v, 2'b00}, "result");
        check(trk_s[c], 16'hE000, "track slots");
        check(pd_s[c], 16'h0001, "power-down slots");
        check(16'(ch_s[c]), 16'(ch), "channel");
    endtask

    initial begin
        #200us;
        n_mismatch++;
        $display("unexpected at %0t: watchdog expired", $time);
        summarize();
    end

    initial begin
        do_reset();
        chan = 1'b0;
        for (int i = 0; i < 6; i++) begin
            in_a = rows[i].in_a;
            in_b = rows[i].in_b;
            i_dacs_host_model.ctrl[0] = rows[i].ctrl;
            i_dacs_host_model.frame(16, rows[i].park_high);
            conv_check(0, rows[i].exp_res, chan);
            chan = rows[i].ctrl[3];
        end
        // Three conversions in one frame, channel sent one ahead
        in_a = 10'h0AB;
        in_b = 10'h354;
        i_dacs_host_model.ctrl = '{8'h08, 8'h00, 8'h08, 8'h00};
        fork
            i_dacs_host_model.frame(48, 1'b0);
            begin
                // Freeze across the ninth falling edge of conversion two
                repeat (196) @(negedge clk);
                frz = stat_w;
                clk_en = 1'b0;
                repeat (2) @(negedge clk);
                check(16'(stat_w), 16'(frz), "frozen outputs");
                clk_en = 1'b1;
            end
        join
        conv_check(0, 10'h0AB, 1'b0);
        conv_check(1, 10'h354, 1'b1);
        conv_check(2, 10'h0AB, 1'b0);
        // Abort before the eighth rise, then clock while deselected
        i_dacs_host_model.ctrl[0] = 8'h00;
        i_dacs_host_model.frame(6, 1'b0);
        i_dacs_host_model.idle(6);
        check(16'(power_down), 16'h0001, "power-down deselected");
        check(16'(track_mode), 16'h0000, "track deselected");
        check(16'(dout_pin === 1'bz), 16'h0001, "pin released");
        i_dacs_host_model.ctrl[0] = 8'h28;
        i_dacs_host_model.frame(16, 1'b1);
        conv_check(0, 10'h354, 1'b1);
        // Reset in mid-run returns to the first input
        do_reset();
        i_dacs_host_model.ctrl[0] = 8'h08;
        i_dacs_host_model.frame(16, 1'b0);
        conv_check(0, 10'h0AB, 1'b0);
        summarize();
    end
endmodule
